// [rtl/ccv_decode.sv]
`timescale 1ns/1ps
`default_nettype none

// Maps a page and address onto a channel and a byte lane
module ccv_decode
  import ccv_pkg::*;
(
  input  wire logic [7:0]            page,
  input  wire logic [7:0]            addr,
  output logic                       hit,
  output logic [CCV_CHAN_W-1:0]      chan,
  output ccv_byte_e                  byte_sel
);

  function automatic logic match_addr(input logic [7:0] a, input logic [7:0] ref_a);
    match_addr = (a == ref_a);
  endfunction

  always_comb begin
    hit      = 1'b0;
    chan     = '0;
    byte_sel = CCV_BYTE_LOW;
    if (page == CCV_SFR_PAGE) begin
      for (int i = 0; i < CCV_NUM_CHAN; i++) begin
        if (match_addr(addr, CCV_LOW_ADDR[i])) begin
          hit      = 1'b1;
          chan     = CCV_CHAN_W'(i);
          byte_sel = CCV_BYTE_LOW;
        end
        if (match_addr(addr, CCV_HIGH_ADDR[i])) begin
          hit      = 1'b1;
          chan     = CCV_CHAN_W'(i);
          byte_sel = CCV_BYTE_HIGH;
        end
      end
    end
  end

endmodule

`default_nettype wire

// [rtl/ccv_pkg.sv]
package ccv_pkg;

  localparam int unsigned CCV_NUM_CHAN   = 6;
  localparam int unsigned CCV_CHAN_W     = 3;
  localparam int unsigned CCV_BYTE_W     = 8;
  localparam int unsigned CCV_VALUE_W    = 16;

  // All value registers sit on one register page
  localparam logic [7:0]  CCV_SFR_PAGE   = 8'h00;

  // Low and high byte addresses, channel 0 in the lowest slot
  localparam logic [CCV_NUM_CHAN-1:0][7:0] CCV_LOW_ADDR = {
    8'hCE, 8'hFD, 8'hED, 8'hEB, 8'hE9, 8'hFB
  };
  localparam logic [CCV_NUM_CHAN-1:0][7:0] CCV_HIGH_ADDR = {
    8'hCF, 8'hFE, 8'hEE, 8'hEC, 8'hEA, 8'hFC
  };

  // Field positions of the 16-bit value
  localparam int unsigned CCV_LOW_LSB    = 0;
  localparam int unsigned CCV_HIGH_LSB   = 8;

  // Reset values
  localparam logic [7:0]  CCV_BYTE_RST   = 8'h00;
  localparam logic [15:0] CCV_VALUE_RST  = 16'h0000;
  localparam logic        CCV_ENABLE_RST = 1'b0;
  localparam logic [7:0]  CCV_RDATA_IDLE = 8'h00;

  typedef enum logic {
    CCV_BYTE_LOW  = 1'b0,
    CCV_BYTE_HIGH = 1'b1
  } ccv_byte_e;

  typedef logic [CCV_NUM_CHAN-1:0][CCV_VALUE_W-1:0] ccv_value_bank_t;

  // Register bus request: page, address, strobes and write data
  typedef struct packed {
    logic [7:0] page;
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } ccv_sfr_req_s;

  // Register bus answer: read data and claim of the address
  typedef struct packed {
    logic [7:0] rdata;
    logic       hit;
  } ccv_sfr_rsp_s;

endpackage

// [rtl/ccv_value_regs.sv]
`timescale 1ns/1ps
`default_nettype none

//Function
// - Each channel's low-byte register holds bits 7 to 0 of that channel's 16-bit match value.
// - Each channel's high-byte register holds bits 15 to 8 of that channel's 16-bit match value.
// - The low-byte address may instead reach the low byte of the channel's PWM auto-reload value.
// - The high-byte address may instead reach the high byte of the channel's PWM auto-reload value.
// - The reload access select bit steers both byte addresses to the match value or the reload value.
// - A software write to a channel's low byte also clears that channel's comparator enable.
// - A software write to a channel's high byte also sets that channel's comparator enable.
// - Six channels each have read/write low and high bytes on page 0x00, all resetting to zero.
module ccv_value_regs
  import ccv_pkg::*;
(
  input  wire logic                      ref_clk,
  input  wire logic                      arst_n,
  input  wire ccv_sfr_req_s              sfr_req,
  input  wire logic                      reload_access_select,
  input  wire logic [CCV_VALUE_W-1:0]    counter_value,
  input  wire logic [CCV_NUM_CHAN-1:0]   capture_event,
  input  wire logic [CCV_NUM_CHAN-1:0]   mode_enable_wr,
  input  wire logic [CCV_NUM_CHAN-1:0]   mode_enable_val,
  output ccv_sfr_rsp_s                   sfr_rsp,
  output ccv_value_bank_t                channel_match_value,
  output ccv_value_bank_t                reload_value,
  output logic [CCV_NUM_CHAN-1:0]        comparator_enable
);

  logic                  dec_hit;
  logic [CCV_CHAN_W-1:0] dec_chan;
  ccv_byte_e             dec_byte;

  ccv_decode u_decode (
    .page     (sfr_req.page),
    .addr     (sfr_req.addr),
    .hit      (dec_hit),
    .chan     (dec_chan),
    .byte_sel (dec_byte)
  );

  // Byte helpers shared by the write and read paths
  function automatic logic [CCV_BYTE_W-1:0] get_byte(input logic [CCV_VALUE_W-1:0] v,
                                                     input ccv_byte_e               b);
    if (b == CCV_BYTE_HIGH) begin
      get_byte = v[CCV_HIGH_LSB +: CCV_BYTE_W];
    end else begin
      get_byte = v[CCV_LOW_LSB +: CCV_BYTE_W];
    end
  endfunction

  function automatic logic [CCV_VALUE_W-1:0] put_byte(input logic [CCV_VALUE_W-1:0] v,
                                                      input ccv_byte_e               b,
                                                      input logic [CCV_BYTE_W-1:0]  d);
    logic [CCV_VALUE_W-1:0] r;
    r = v;
    if (b == CCV_BYTE_HIGH) begin
      r[CCV_HIGH_LSB +: CCV_BYTE_W] = d;
    end else begin
      r[CCV_LOW_LSB +: CCV_BYTE_W] = d;
    end
    put_byte = r;
  endfunction

  // Per-channel write strobes split by target
  logic [CCV_NUM_CHAN-1:0] wr_match;
  logic [CCV_NUM_CHAN-1:0] wr_reload;
  logic [CCV_NUM_CHAN-1:0] wr_any;

  always_comb begin
    wr_match  = '0;
    wr_reload = '0;
    wr_any    = '0;
    for (int i = 0; i < CCV_NUM_CHAN; i++) begin
      if (sfr_req.wr && dec_hit && (dec_chan == CCV_CHAN_W'(i))) begin
        wr_any[i] = 1'b1;
        if (reload_access_select) begin
          wr_reload[i] = 1'b1;
        end else begin
          wr_match[i] = 1'b1;
        end
      end
    end
  end

  // Next values of the match bank
  ccv_value_bank_t next_match;

  always_comb begin
    next_match = channel_match_value;
    for (int i = 0; i < CCV_NUM_CHAN; i++) begin
      if (capture_event[i]) begin
        next_match[i] = counter_value;
      end else if (wr_match[i]) begin
        next_match[i] = put_byte(channel_match_value[i], dec_byte, sfr_req.wdata);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      channel_match_value <= {CCV_NUM_CHAN{CCV_VALUE_RST}};
    end else begin
      channel_match_value <= next_match;
    end
  end

  // Next values of the auto-reload bank
  ccv_value_bank_t next_reload;

  always_comb begin
    next_reload = reload_value;
    for (int i = 0; i < CCV_NUM_CHAN; i++) begin
      if (wr_reload[i]) begin
        next_reload[i] = put_byte(reload_value[i], dec_byte, sfr_req.wdata);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reload_value <= {CCV_NUM_CHAN{CCV_VALUE_RST}};
    end else begin
      reload_value <= next_reload;
    end
  end

  // Comparator enable: byte writes override a same-cycle mode write
  logic [CCV_NUM_CHAN-1:0] next_enable;

  always_comb begin
    next_enable = comparator_enable;
    for (int i = 0; i < CCV_NUM_CHAN; i++) begin
      if (mode_enable_wr[i]) begin
        next_enable[i] = mode_enable_val[i];
      end
      if (wr_any[i]) begin
        if (dec_byte == CCV_BYTE_HIGH) begin
          next_enable[i] = 1'b1;
        end else begin
          next_enable[i] = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      comparator_enable <= {CCV_NUM_CHAN{CCV_ENABLE_RST}};
    end else begin
      comparator_enable <= next_enable;
    end
  end

  // Read path: data registered one cycle after the read strobe
  logic [CCV_BYTE_W-1:0] next_rdata;

  always_comb begin
    next_rdata = CCV_RDATA_IDLE;
    for (int i = 0; i < CCV_NUM_CHAN; i++) begin
      if (dec_chan == CCV_CHAN_W'(i)) begin
        if (reload_access_select) begin
          next_rdata = get_byte(reload_value[i], dec_byte);
        end else begin
          next_rdata = get_byte(channel_match_value[i], dec_byte);
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sfr_rsp.rdata <= CCV_RDATA_IDLE;
      sfr_rsp.hit   <= 1'b0;
    end else if (sfr_req.rd && dec_hit) begin
      sfr_rsp.rdata <= next_rdata;
      sfr_rsp.hit   <= 1'b1;
    end else begin
      sfr_rsp.rdata <= CCV_RDATA_IDLE;
      sfr_rsp.hit   <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// [sim/ccv_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module ccv_chk
  import ccv_pkg::*;
(
  input wire logic            ref_clk,
  input wire logic            arst_n,
  input wire ccv_sfr_req_s    sfr_req,
  input wire logic            reload_access_select,
  input wire logic [15:0]     counter_value,
  input wire logic [5:0]      capture_event,
  input wire ccv_sfr_rsp_s    sfr_rsp,
  input wire ccv_value_bank_t channel_match_value,
  input wire ccv_value_bank_t reload_value,
  input wire logic [5:0]      comparator_enable
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  wire logic wp  = sfr_req.wr && sfr_req.page == 8'h00;
  wire logic wl  = wp && sfr_req.addr == 8'hFB;
  wire logic wh  = wp && sfr_req.addr == 8'hFC;
  wire logic sel = reload_access_select;
  // Read of the channel 0 high byte, answered one cycle later
  sequence s_rd_high0;
    sfr_req.rd && sfr_req.page == 8'h00 && sfr_req.addr == 8'hFC ##1 sfr_rsp.hit;
  endsequence
  chk_low_byte:
    assert property (wl && !sel && !capture_event[0] |=> channel_match_value[0][7:0] == $past(sfr_req.wdata))
      else $error("low byte write lost");
  chk_high_byte:
    assert property (wh && !sel && !capture_event[0] |=> channel_match_value[0][15:8] == $past(sfr_req.wdata))
      else $error("high byte write lost");
  chk_reload_low:
    assert property (wl && sel |=> reload_value[0][7:0] == $past(sfr_req.wdata)) else $error("reload low lost");
  chk_reload_high:
    assert property (wh && sel |=> reload_value[0][15:8] == $past(sfr_req.wdata)) else $error("reload high lost");
  chk_select_keeps_match:
    assert property (wl && sel && !capture_event[0] |=> $stable(channel_match_value[0]))
      else $error("match changed under select");
  chk_low_clears_en:
    assert property (wl |=> !comparator_enable[0]) else $error("enable not cleared");
  chk_high_sets_en:
    assert property (wh |=> comparator_enable[0]) else $error("enable not set");
  chk_read_hit:
    assert property (sfr_req.rd && sfr_req.page == 8'h00 && sfr_req.addr == 8'hFC |-> s_rd_high0)
      else $error("read not answered");
  chk_unmapped_quiet:
    assert property (sfr_req.rd && sfr_req.addr == 8'hD9 |=> !sfr_rsp.hit && sfr_rsp.rdata == 8'h00)
      else $error("unmapped read answered");
  chk_capture_load:
    assert property (capture_event[0] |=> channel_match_value[0] == $past(counter_value)) else $error("capture lost");
endmodule
bind ccv_value_regs ccv_chk u_chk (.ref_clk(ref_clk), .arst_n(arst_n), .sfr_req(sfr_req),
  .reload_access_select(reload_access_select), .counter_value(counter_value), .capture_event(capture_event),
  .sfr_rsp(sfr_rsp), .channel_match_value(channel_match_value), .reload_value(reload_value),
  .comparator_enable(comparator_enable));
`default_nettype wire

// [sim/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module tb_top
  import ccv_pkg::*;
;
  logic            ref_clk = 1'b0;
  logic            arst_n  = 1'b0;
  logic            sel     = 1'b0;
  ccv_sfr_req_s    req     = '0;
  logic [15:0]     cnt     = 16'h0000;
  logic [5:0]      cap     = 6'h00;
  logic [5:0]      mwr     = 6'h00;
  logic [5:0]      mval    = 6'h00;
  ccv_sfr_rsp_s    rsp;
  ccv_value_bank_t mv;
  ccv_value_bank_t rv;
  logic [5:0]      en;
  int              error_cnt = 0;
  int              samples_checked = 0;
  always #4 ref_clk = ~ref_clk;
  ccv_value_regs DUT (.ref_clk(ref_clk), .arst_n(arst_n), .sfr_req(req), .reload_access_select(sel),
    .counter_value(cnt), .capture_event(cap), .mode_enable_wr(mwr), .mode_enable_val(mval),
    .sfr_rsp(rsp), .channel_match_value(mv), .reload_value(rv), .comparator_enable(en));
  // One register access, outputs settled on return
  task automatic acc(input logic w, input logic s, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    sel <= s;
    req <= '{page: 8'h00, addr: a, wr: w, rd: !w, wdata: d};
    @(posedge ref_clk);
    req.wr <= 1'b0;
    req.rd <= 1'b0;
    #1;
  endtask
  task automatic rd_chk(input logic s, input logic [7:0] a, input logic [7:0] e, input logic h);
    acc(1'b0, s, a, 8'h00);
    `CHK("hit", h, rsp.hit)
    `CHK("rdata", e, rsp.rdata)
  endtask
  task automatic t_reset;
    for (int i = 0; i < 6; i++) begin
      rd_chk(1'b0, CCV_LOW_ADDR[i], 8'h00, 1'b1);
      rd_chk(1'b0, CCV_HIGH_ADDR[i], 8'h00, 1'b1);
    end
    `CHK("enable", 6'h00, en)
  endtask
  task automatic t_bytes;
    for (int i = 0; i < 6; i++) begin
      acc(1'b1, 1'b0, CCV_HIGH_ADDR[i], 8'(8'h30 + i));
      `CHK("en set", 1'b1, en[i])
      acc(1'b1, 1'b0, CCV_LOW_ADDR[i], 8'(8'hA0 + i));
      `CHK("en clr", 1'b0, en[i])
      `CHK("match", {8'(8'h30 + i), 8'(8'hA0 + i)}, mv[i])
      rd_chk(1'b0, CCV_HIGH_ADDR[i], 8'(8'h30 + i), 1'b1);
      rd_chk(1'b0, CCV_LOW_ADDR[i], 8'(8'hA0 + i), 1'b1);
    end
  endtask
  task automatic t_reload;
    acc(1'b1, 1'b1, 8'hFB, 8'h5A);
    acc(1'b1, 1'b1, 8'hFC, 8'hC3);
    `CHK("en sel", 1'b1, en[0])
    `CHK("reload", 16'hC35A, rv[0])
    `CHK("match kept", 16'h30A0, mv[0])
    rd_chk(1'b1, 8'hFC, 8'hC3, 1'b1);
    rd_chk(1'b1, 8'hFB, 8'h5A, 1'b1);
    rd_chk(1'b0, 8'hFB, 8'hA0, 1'b1);
    rd_chk(1'b0, 8'hFC, 8'h30, 1'b1);
  endtask
  task automatic t_capture;
    @(posedge ref_clk);
    cnt <= 16'hA5C3;
    cap <= 6'h21;
    @(posedge ref_clk);
    cap <= 6'h00;
    #1;
    `CHK("cap0", 16'hA5C3, mv[0])
    `CHK("cap5", 16'hA5C3, mv[5])
    `CHK("cap2", 16'h32A2, mv[2])
  endtask
  task automatic t_misc;
    @(posedge ref_clk);
    mwr <= 6'h08;
    mval <= 6'h08;
    @(posedge ref_clk);
    mwr <= 6'h00;
    #1;
    `CHK("mode en", 6'h09, en)
    acc(1'b1, 1'b0, 8'hED, 8'h00);
    `CHK("en low wr", 6'h01, en)
    rd_chk(1'b0, 8'hD9, 8'h00, 1'b0);
    // Access on another page must be ignored
    @(posedge ref_clk);
    req <= '{page: 8'h01, addr: 8'hFB, wr: 1'b1, rd: 1'b1, wdata: 8'hFF};
    @(posedge ref_clk);
    req <= '0;
    #1;
    `CHK("page hit", 1'b0, rsp.hit)
    `CHK("page wr", 16'hA5C3, mv[0])
    `CHK("page en", 6'h01, en)
  endtask
  task automatic report_and_stop;
    if (error_cnt == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_reset;
    t_bytes;
    t_reload;
    t_capture;
    t_misc;
    report_and_stop;
  end
endmodule
`default_nettype wire
